/* File: bench/bcd_select_checker.sv */
// Purpose: Port-level checks for the select scanner
// Assumes: Offsets and fields from the shared header
// Notes:   Shadows CTRL and SCAN_TIME from the writes it sees
`timescale 1ns/1ns
`include "bcd_select_regs.svh"

module bcd_select_checker #(
    parameter int NUM_PINS      = 6,
    parameter int CYCLES_PER_MS = 25000
) (
    input wire logic                ref_clk,
    input wire logic                reset_n,
    input wire logic [7:0]          reg_addr,
    input wire logic [31:0]         reg_wdata,
    input wire logic                reg_wr,
    input wire logic                reg_rd,
    input wire logic [31:0]         reg_rdata,
    input wire logic [NUM_PINS-1:0] select_pin,
    input wire logic                run_start,
    input wire logic [5:0]          run_seq,
    input wire logic                run_done,
    input wire logic                store_req,
    input wire logic                store_done
);
    logic [3:0]          ctrl_q;
    logic [15:0]         scan_q;
    logic [NUM_PINS-1:0] prev_q;
    logic [NUM_PINS-1:0] masked;
    logic [31:0]         cnt_q;
    logic                boot_q, up_q, busy_q, zero_q, sbusy_q;

    // Narrow roles only see the low pins
    assign masked = select_pin & ((ctrl_q[3:2] == `ROLE_ALL_SELECT) ? '1 :
                    NUM_PINS'((1 << `PART_SELECT_PINS) - 1));

    // Shadow state; a mid-run reset reloads it as the design does
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= `CTRL_RESET;
            scan_q <= `SCAN_RESET_MS;
            prev_q <= '0;
            cnt_q <= '0;
            {boot_q, up_q, busy_q, zero_q, sbusy_q} <= 5'b10010;
        end else begin
            ctrl_q <= (reg_wr && reg_addr == `OFS_CTRL) ? reg_wdata[3:0] : ctrl_q;
            scan_q <= (reg_wr && reg_addr == `OFS_SCAN_TIME) ? reg_wdata[15:0] : scan_q;
            prev_q <= masked;
            cnt_q <= (masked != prev_q) ? '0 : cnt_q + 1;
            boot_q <= 1'b0;
            up_q <= up_q | run_start;
            busy_q <= run_start | (busy_q & ~run_done);
            zero_q <= ~run_start & (zero_q | (masked == '0));
            sbusy_q <= store_req | (sbusy_q & ~store_done);
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence s_store_cmd;
        reg_wr && reg_addr == `OFS_CMD && reg_wdata[`CMD_STORE_BIT];
    endsequence
    property p_powerup; boot_q |=> run_start && run_seq == `SEQ_POWERUP; endproperty
    property p_one_run; busy_q |-> !run_start; endproperty
    property p_range; run_start && up_q |-> run_seq inside {[1:`SEQ_LAST_USER]}; endproperty
    // Launch count has sampling slack of two cycles
    property p_stable; run_start && up_q |-> cnt_q + 2 >= 32'(scan_q) * CYCLES_PER_MS; endproperty
    property p_decode; run_start && up_q |-> run_seq == 6'(masked); endproperty
    property p_zero; run_start && up_q && ctrl_q[`CTRL_INTR_BIT] |-> zero_q; endproperty
    property p_store; s_store_cmd ##0 !sbusy_q |=> store_req; endproperty
    property p_rdata_idle; !$past(reg_rd) |-> reg_rdata == '0; endproperty

    a_powerup: assert property (p_powerup) else $error("no power-up launch");
    a_one_run: assert property (p_one_run) else $error("launch during run");
    a_range: assert property (p_range) else $error("launch out of range");
    a_stable: assert property (p_stable) else $error("launch too early");
    a_decode: assert property (p_decode) else $error("bad number");
    a_zero: assert property (p_zero) else $error("no zero between picks");
    a_store: assert property (p_store) else $error("store not requested");
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
endmodule : bcd_select_checker

bind bcd_select_scanner bcd_select_checker #(.NUM_PINS(NUM_PINS),
    .CYCLES_PER_MS(CYCLES_PER_MS)) chk (.ref_clk(ref_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .select_pin(select_pin), .run_start(run_start),
    .run_seq(run_seq), .run_done(run_done), .store_req(store_req), .store_done(store_done));

/* File: bench/bcd_select_scanner_test.sv */
// Purpose: Directed test of the select scanner through its ports
// Assumes: Four clocks per millisecond to keep scan times short
// Notes:   Pins are held still near expected launches
`timescale 1ns/1ns
`include "bcd_select_regs.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value at %0t: got %h want %h", $time, g, e); end end

module bcd_select_scanner_test;
    logic        ref_clk, reset_n, reg_wr, reg_rd, run_start, run_done, store_req;
    logic        store_done, slow;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [5:0]  select_pin, run_seq;
    int          miscompares, tests_run, cycles;

    always #20 ref_clk = ~ref_clk;

    bcd_select_scanner #(.NUM_PINS(6), .CYCLES_PER_MS(4)) dut (.ref_clk(ref_clk),
        .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .select_pin(select_pin),
        .run_start(run_start), .run_seq(run_seq), .run_done(run_done),
        .store_req(store_req), .store_done(store_done));
    run_partner partner (.ref_clk(ref_clk), .reset_n(reset_n), .slow(slow),
        .run_start(run_start), .store_req(store_req), .run_done(run_done),
        .store_done(store_done));

    task automatic end_sim;
        $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim

    // Hang guard, far above the four hundred or so cycles needed
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 6000) begin
            miscompares++;
            end_sim();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata & m, e)
    endtask : rd

    task automatic pins(input logic [5:0] v);
        @(posedge ref_clk);
        select_pin <= v;
    endtask : pins

    // Bounded wait for the next launch pulse
    task automatic launch(input logic [5:0] e);
        int n;
        n = 0;
        while (run_start !== 1'b1 && n < 500) begin
            @(negedge ref_clk);
            n++;
        end
        `CHK(run_start, 1'b1)
        `CHK(run_seq, e)
        @(negedge ref_clk);
    endtask : launch

    task automatic quiet(input int c);
        repeat (c) begin
            @(negedge ref_clk);
            `CHK(run_start, 1'b0)
        end
    endtask : quiet

    initial begin
        {ref_clk, reset_n, reg_wr, reg_rd, slow} = '0;
        {reg_addr, reg_wdata, select_pin} = '0;
        {miscompares, tests_run, cycles} = '0;
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        launch(`SEQ_POWERUP);
        rd(`OFS_CTRL, '1, '0);
        rd(`OFS_SCAN_TIME, 32'hFFFF, 32'(`SCAN_RESET_MS));
        rd(`OFS_CMD, '1, '0);
        rd(8'h10, '1, '0);
        wr(`OFS_SCAN_TIME, 32'h2);
        wr(`OFS_CTRL, 32'hF);
        rd(`OFS_CTRL, '1, 32'hF);
        pins(6'h05);
        repeat (4) @(posedge ref_clk);
        pins(6'h00);
        quiet(30);
        pins(`SEQ_LAST_USER);
        launch(`SEQ_LAST_USER);
        quiet(40);
        rd(`OFS_STATUS, 32'h003F_0002, 32'h0027_0002);
        pins(6'h00);
        repeat (12) @(posedge ref_clk);
        pins(6'h03);
        launch(6'h03);
        pins(6'h00);
        repeat (12) @(posedge ref_clk);
        pins(`SEQ_POWERUP);
        quiet(30);
        rd(`OFS_STATUS, 32'h10, 32'h10);
        // Drop the over-range value first, since a standing set beats the clear
        pins(6'h00);
        wr(`OFS_CMD, 32'h2);
        rd(`OFS_STATUS, 32'h10, 32'h0);
        wr(`OFS_CTRL, 32'hD);
        slow <= 1'b1;
        pins(6'h02);
        launch(6'h02);
        pins(6'h07);
        quiet(25);
        launch(6'h07);
        launch(6'h07);
        wr(`OFS_CTRL, 32'h0);
        slow <= 1'b0;
        repeat (50) @(posedge ref_clk);
        pins(6'h3E);
        wr(`OFS_CTRL, 32'h1);
        launch(6'h06);
        wr(`OFS_CTRL, 32'h0);
        wr(`OFS_CMD, 32'h1);
        #1;
        `CHK(store_req, 1'b1)
        rd(`OFS_STATUS, 32'h8, 32'h8);
        repeat (20) @(posedge ref_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        launch(`SEQ_POWERUP);
        end_sim();
    end
endmodule : bcd_select_scanner_test

/* File: bench/run_partner.sv */
// Purpose: Behavioural executor and store beyond the scanner
// Assumes: One run and one store outstanding at a time
// Notes:   slow stretches runs so pin changes land mid-run
`timescale 1ns/1ns

module run_partner (
    input  wire logic ref_clk,
    input  wire logic reset_n,
    input  wire logic slow,
    input  wire logic run_start,
    input  wire logic store_req,
    output logic      run_done,
    output logic      store_done
);
    logic [5:0] run_q;
    logic [5:0] sto_q;

    // Countdowns; each done fires as its count reaches one
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            run_q <= '0;
            sto_q <= '0;
        end else begin
            run_q <= run_start ? (slow ? 6'h28 : 6'h03) : run_q - 6'(run_q != '0);
            sto_q <= store_req ? 6'h05 : sto_q - 6'(sto_q != '0);
        end
    end

    assign run_done   = run_q == 6'h01;
    assign store_done = sto_q == 6'h01;
endmodule : run_partner

/* File: src/bcd_select_pkg.sv */
// Purpose: Types shared by the select scanner
// Assumes: Constants come from bcd_select_regs.svh
// Notes:   Holds the sequencing state enumeration only
package bcd_select_pkg;

    typedef enum logic [2:0] {
        ST_POWERUP   = 3'b000,
        ST_RUN       = 3'b001,
        ST_SCAN      = 3'b010,
        ST_WAIT_ZERO = 3'b011,
        ST_IDLE      = 3'b100
    } scan_state_t;

endpackage : bcd_select_pkg

/* File: src/bcd_select_regs.svh */
// Purpose: Offsets, field positions, reset values and timing for the select scanner
// Assumes: 25 MHz ref_clk, 32-bit register port with byte addresses
// Notes:   Definitions only; included by both design files
`ifndef BCD_SELECT_REGS_SVH
`define BCD_SELECT_REGS_SVH

// Register byte offsets
`define OFS_CTRL         8'h00
`define OFS_SCAN_TIME    8'h04
`define OFS_STATUS       8'h08
`define OFS_CMD          8'h0C

// Control fields
`define CTRL_ENABLE_BIT  0
`define CTRL_INTR_BIT    1
`define CTRL_ROLE_LSB    2
`define CTRL_ROLE_MSB    3

// Status fields
`define STAT_BUSY_BIT    0
`define STAT_WZERO_BIT   1
`define STAT_STABLE_BIT  2
`define STAT_STORE_BIT   3
`define STAT_REJECT_BIT  4
`define STAT_SEQ_LSB     8
`define STAT_VAL_LSB     16

// Command fields
`define CMD_STORE_BIT    0
`define CMD_CLR_REJ_BIT  1

// Reset values and the all-select role code
`define CTRL_RESET       4'h0
`define SCAN_RESET_MS    16'h0014
`define ROLE_ALL_SELECT  2'h3

// Sequence numbers
`define SEQ_POWERUP      6'h28
`define SEQ_LAST_USER    6'h27
`define SEQ_NONE         6'h00

// Timing and the partial-role pin count
`define CLK_HZ           25_000_000
`define HZ_PER_KHZ       1000
`define PART_SELECT_PINS 3

`endif

/* File: src/bcd_select_scanner.sv */
// Purpose: Scan PLC select lines, pick a stored sequence and launch it
// Assumes: An outside executor runs sequences and pulses run_done
// Notes:   Registers on a plain strobe port, read data one cycle late
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
`include "bcd_select_regs.svh"

module bcd_select_scanner
    import bcd_select_pkg::*;
#(
    parameter int NUM_PINS      = 6,
    parameter int CYCLES_PER_MS = `CLK_HZ / `HZ_PER_KHZ
) (
    input  wire logic                ref_clk,
    input  wire logic                reset_n,
    // Register port
    input  wire logic [7:0]          reg_addr,
    input  wire logic [31:0]         reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic [31:0]              reg_rdata,
    // PLC select pins
    input  wire logic [NUM_PINS-1:0] select_pin,
    // Sequence executor
    output logic                     run_start,
    output logic [5:0]               run_seq,
    input  wire logic                run_done,
    // Nonvolatile store
    output logic                     store_req,
    input  wire logic                store_done
);

    // Settings held in registers
    logic              bcd_select_enable_q;
    logic              interrupted_run_setting_q;
    logic [1:0]        input_role_setting_q;
    logic [15:0]       stability_time_setting_q;

    // Sequencing state
    scan_state_t       state_q;
    scan_state_t       state_d;
    logic              run_start_q;
    logic [5:0]        run_seq_q;
    logic              store_req_q;
    logic              store_busy_q;
    logic              reject_q;
    logic [31:0]       rdata_q;

    // Debouncer outputs
    logic [NUM_PINS-1:0] stable_value;
    logic                stable;
    logic [NUM_PINS-1:0] sampled;

    // Register decode
    wire  wr_ctrl  = reg_wr && (reg_addr == `OFS_CTRL);
    wire  wr_scan  = reg_wr && (reg_addr == `OFS_SCAN_TIME);
    wire  wr_cmd   = reg_wr && (reg_addr == `OFS_CMD);
    wire  all_sel  = (input_role_setting_q == `ROLE_ALL_SELECT);

    // Select number from the stable pins
    logic [5:0] picked;
    assign picked = 6'(stable_value);

    wire  pick_zero  = stable && (picked == `SEQ_NONE);
    wire  pick_valid = stable && (picked != `SEQ_NONE) && (picked <= `SEQ_LAST_USER);
    wire  pick_over  = stable && (picked > `SEQ_LAST_USER);
    wire  launch     = (state_q == ST_SCAN) && pick_valid;
    wire  launch_pu  = (state_q == ST_POWERUP);

    select_debouncer #(
        .NUM_PINS      (NUM_PINS),
        .CYCLES_PER_MS (CYCLES_PER_MS)
    ) u_debouncer (
        .ref_clk      (ref_clk),
        .reset_n      (reset_n),
        .select_pin   (select_pin),
        .all_lines    (all_sel),
        .scan_ms      (stability_time_setting_q),
        .stable_value (stable_value),
        .stable       (stable),
        .sampled      (sampled)
    );

    // Next state of the sequencer
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_POWERUP: begin
                state_d = ST_RUN;
            end
            ST_RUN: begin
                // Inputs are ignored until the sequence ends
                if (run_done) begin
                    if (!bcd_select_enable_q) begin
                        state_d = ST_IDLE;
                    end else if (interrupted_run_setting_q) begin
                        state_d = ST_WAIT_ZERO;
                    end else begin
                        state_d = ST_SCAN;
                    end
                end
            end
            ST_SCAN: begin
                if (!bcd_select_enable_q) begin
                    state_d = ST_IDLE;
                end else if (pick_valid) begin
                    state_d = ST_RUN;
                end
            end
            ST_WAIT_ZERO: begin
                if (!bcd_select_enable_q) begin
                    state_d = ST_IDLE;
                end else if (pick_zero) begin
                    state_d = ST_SCAN;
                end
            end
            ST_IDLE: begin
                if (bcd_select_enable_q) begin
                    state_d = interrupted_run_setting_q ? ST_WAIT_ZERO : ST_SCAN;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // State register; power-up sequence is the first thing after reset
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_POWERUP;
        end else begin
            state_q <= state_d;
        end
    end

    // Launch pulse and sequence number to the executor
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            run_start_q <= 1'b0;
            run_seq_q   <= `SEQ_NONE;
        end else begin
            run_start_q <= launch || launch_pu;
            if (launch_pu) begin
                run_seq_q <= `SEQ_POWERUP;
            end else if (launch) begin
                run_seq_q <= picked;
            end
        end
    end

    // Settings; sequence forty writes these over the register port
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            bcd_select_enable_q       <= 1'(`CTRL_RESET >> `CTRL_ENABLE_BIT);
            interrupted_run_setting_q <= 1'b0;
            input_role_setting_q      <= 2'h0;
        end else if (wr_ctrl) begin
            bcd_select_enable_q       <= reg_wdata[`CTRL_ENABLE_BIT];
            interrupted_run_setting_q <= reg_wdata[`CTRL_INTR_BIT];
            input_role_setting_q      <= reg_wdata[`CTRL_ROLE_MSB:`CTRL_ROLE_LSB];
        end
    end

    // Scan time in milliseconds
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            stability_time_setting_q <= `SCAN_RESET_MS;
        end else if (wr_scan) begin
            stability_time_setting_q <= reg_wdata[15:0];
        end
    end

    // Store command; busy until the storage answers
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            store_req_q  <= 1'b0;
            store_busy_q <= 1'b0;
        end else begin
            // A second request while busy is dropped, not queued
            store_req_q <= wr_cmd && reg_wdata[`CMD_STORE_BIT] && !store_busy_q;
            if (store_req_q) begin
                store_busy_q <= 1'b1;
            end else if (store_done) begin
                store_busy_q <= 1'b0;
            end
        end
    end

    // Sticky flag for numbers above the user range; set beats clear
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            reject_q <= 1'b0;
        end else if ((state_q == ST_SCAN) && pick_over) begin
            reject_q <= 1'b1;
        end else if (wr_cmd && reg_wdata[`CMD_CLR_REJ_BIT]) begin
            reject_q <= 1'b0;
        end
    end

    // Read mux; unmapped offsets read zero
    logic [31:0] status_word;
    logic [31:0] rd_mux;
    always_comb begin
        status_word = '0;
        status_word[`STAT_BUSY_BIT]   = (state_q == ST_RUN) || (state_q == ST_POWERUP);
        status_word[`STAT_WZERO_BIT]  = (state_q == ST_WAIT_ZERO);
        status_word[`STAT_STABLE_BIT] = stable;
        status_word[`STAT_STORE_BIT]  = store_busy_q;
        status_word[`STAT_REJECT_BIT] = reject_q;
        status_word[`STAT_SEQ_LSB +: 6] = run_seq_q;
        status_word[`STAT_VAL_LSB +: NUM_PINS] = sampled;
        unique case (reg_addr)
            `OFS_CTRL: begin
                rd_mux = {28'h000_0000, input_role_setting_q,
                          interrupted_run_setting_q, bcd_select_enable_q};
            end
            `OFS_SCAN_TIME: begin
                rd_mux = {16'h0000, stability_time_setting_q};
            end
            `OFS_STATUS: begin
                rd_mux = status_word;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
        end
    end

    assign reg_rdata = rdata_q;
    assign run_start = run_start_q;
    assign run_seq   = run_seq_q;
    assign store_req = store_req_q;

endmodule : bcd_select_scanner

/* File: src/select_debouncer.sv */
// Purpose: Sample select pins and flag a value held for the scan time
// Assumes: Pins synchronous to ref_clk
// Notes:   Stable drops the cycle after any change of the masked pins
`timescale 1ns/1ns
`include "bcd_select_regs.svh"

module select_debouncer #(
    parameter int NUM_PINS      = 6,
    parameter int CYCLES_PER_MS = 25000
) (
    input  wire logic                ref_clk,
    input  wire logic                reset_n,
    input  wire logic [NUM_PINS-1:0] select_pin,
    input  wire logic                all_lines,
    input  wire logic [15:0]         scan_ms,
    output logic [NUM_PINS-1:0]      stable_value,
    output logic                     stable,
    output logic [NUM_PINS-1:0]      sampled
);

    localparam int PW = $clog2(CYCLES_PER_MS + 1);
    localparam logic [PW-1:0] PRE_LAST = PW'(CYCLES_PER_MS - 1);

    logic [NUM_PINS-1:0] masked;
    logic [NUM_PINS-1:0] sample_q;
    logic [PW-1:0]       pre_q;
    logic [15:0]         ms_q;
    logic                changed;
    logic                held;
    logic                ms_tick;

    // Role masks the trigger pins out unless all six are select lines
    genvar i;
    generate
        for (i = 0; i < NUM_PINS; i++) begin : g_mask
            assign masked[i] = select_pin[i] & (all_lines | (i < `PART_SELECT_PINS));
        end
    endgenerate

    assign changed = (masked != sample_q);
    assign held    = (ms_q >= scan_ms);
    assign ms_tick = (pre_q == PRE_LAST);
    assign sampled = sample_q;

    // Sample register
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sample_q <= '0;
        end else begin
            sample_q <= masked;
        end
    end

    // Millisecond stability count, restarted on every change
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pre_q        <= '0;
            ms_q         <= '0;
            stable       <= 1'b0;
            stable_value <= '0;
        end else if (changed) begin
            pre_q  <= '0;
            ms_q   <= '0;
            stable <= 1'b0;
        end else if (held) begin
            stable       <= 1'b1;
            stable_value <= sample_q;
        end else begin
            pre_q <= ms_tick ? '0 : pre_q + 1'b1;
            ms_q  <= ms_tick ? ms_q + 16'h0001 : ms_q;
        end
    end

endmodule : select_debouncer
